//--- rtl/register_calc_queue_unit.sv
`timescale 1ns/1ps
// How it works
// (RULE1) Queue init stores size, clears head and used count.
// (RULE2) Strict push head inserts constant, returns used count, errors on overflow.
// (RULE3) Strict pop head moves head entry to result, errors when empty.
// (RULE4) Strict push tail inserts constant, returns used count, errors on overflow.
// (RULE5) Strict pop tail moves tail entry to result, errors when empty.
// (RULE6) Strict element read copies indexed entry, errors when index not occupied.
// (RULE7) Flag push head: zero flag on success, negative on overflow, no error.
// (RULE8) Flag pop head: zero flag on success, negative on underflow.
// (RULE9) Flag push tail: zero flag on success, negative on overflow.
// (RULE10) Flag pop tail: zero flag on success, negative on underflow.
// (RULE11) Flag element read: zero flag on success, negative when out of bounds.
// (RULE12) Unsigned multiply writes full 64-bit product to two consecutive registers.
// (RULE13) Divides 64-bit two-register dividend by 32-bit divisor, writes quotient.
// (RULE14) Integer square root of 64-bit two-register operand, 32-bit result.
// (RULE15) Host sends frame: command, source, constant, operation, option/result word.
// (RULE16) Low byte is result register; upper byte 0x01 pre-saves it to accumulator.
// (RULE17) Each thread owns its accumulator and zero/positive/negative flags.
// (RULE18) Every calculation leaves exactly one of zero, positive, negative set.
// (RULE19) Queue header and entries sit from base register; indices wrap at size.
module register_calc_queue_unit #(
  parameter int NREGS = calc_queue_pkg::NUM_REGS
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Command frame
  input wire logic i_cmd_valid,
  input wire logic [15:0] i_cmd_num,
  input wire logic [15:0] i_src_reg,
  input wire logic [31:0] i_constant,
  input wire logic [15:0] i_op,
  input wire logic [15:0] i_opt_res,
  input wire logic i_thread,
  // Register access
  input wire logic i_reg_we,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_thread,
  input wire logic [31:0] i_reg_wdata,
  output logic [31:0] o_reg_rdata,
  // Status
  output logic o_busy,
  output logic o_done,
  output logic o_cmd_err,
  output logic [1:0] o_zero,
  output logic [1:0] o_pos,
  output logic [1:0] o_neg
);

  calc_queue_pkg::state_t st_r, st_nxt;
  logic [31:0] mem [NREGS];
  logic [31:0] acc_r [2];
  logic [2:0] flag_r [2];
  logic [2:0] flag_nxt [2];
  logic [7:0] src_r, src_nxt, res_r, res_nxt;
  logic [31:0] k_r, k_nxt;
  logic [15:0] op_r, op_nxt;
  logic thd_r, thd_nxt, pre_r, pre_nxt, errf_r, errf_nxt;
  logic [7:0] wa_r [4];
  logic [7:0] wa_nxt [4];
  logic [31:0] wd_r [4];
  logic [31:0] wd_nxt [4];
  logic [3:0] wv_r, wv_nxt;
  logic [1:0] wi_r, wi_nxt;
  logic [63:0] dv_r, dv_nxt;
  logic [34:0] rem_r, rem_nxt;
  logic [31:0] root_r, root_nxt;
  logic [6:0] cnt_r, cnt_nxt;
  logic busy_nxt, done_nxt, err_nxt;
  logic [31:0] rdata_nxt;
  logic mem_we, acc_we, acc_wt;
  logic [7:0] mem_wa;
  logic [31:0] mem_wd, acc_wd;

  function automatic logic [31:0] rd(input logic t, input logic [7:0] a);
    return (a == calc_queue_pkg::ACC_REG) ? acc_r[t] : mem[a]; // RULE17
  endfunction

  function automatic logic [2:0] flg(input logic [63:0] v);
    if (v == 64'h0000_0000_0000_0000) begin
      return calc_queue_pkg::FLAG_ZERO;
    end
    return v[63] ? calc_queue_pkg::FLAG_NEG : calc_queue_pkg::FLAG_POS;
  endfunction

  // Queue header fields, read straight from the register file
  logic [31:0] a_val, a_hi, qsz, qhd, qcn;
  logic [31:0] hm1, hp1, tpos, tlast, epos;
  logic q_full, q_empty, q_oob;
  logic [63:0] prod;
  assign a_val = rd(thd_r, src_r);
  assign a_hi = rd(thd_r, src_r + 8'h01);
  assign qsz = rd(thd_r, src_r + calc_queue_pkg::Q_SIZE_OFS); // RULE19
  assign qhd = rd(thd_r, src_r + calc_queue_pkg::Q_HEAD_OFS);
  assign qcn = rd(thd_r, src_r + calc_queue_pkg::Q_CNT_OFS);
  assign q_full = (qcn >= qsz);
  assign q_empty = (qcn == 32'h0000_0000);
  assign q_oob = (k_r >= qcn);

  // Head stays below size and count at most size, so one subtraction suffices to wrap
  function automatic logic [31:0] wrap(input logic [31:0] s, input logic [31:0] m);
    return (s >= m) ? s - m : s;
  endfunction

  function automatic logic [7:0] ent(input logic [7:0] b, input logic [31:0] p);
    return b + calc_queue_pkg::Q_DATA_OFS + p[7:0];
  endfunction

  assign hm1 = (qhd == 32'h0000_0000) ? qsz - 32'h0000_0001 : qhd - 32'h0000_0001; // RULE19
  assign hp1 = wrap(qhd + 32'h0000_0001, qsz);
  assign tpos = wrap(qhd + qcn, qsz);
  assign tlast = wrap(qhd + qcn - 32'h0000_0001, qsz);
  assign epos = wrap(qhd + k_r, qsz);
  assign prod = {32'h0000_0000, a_val} * {32'h0000_0000, k_r}; // RULE12

  // Iterative divide and square root steps
  logic [32:0] d_try;
  logic d_ge;
  logic [34:0] s_try, s_trial;
  logic s_ge;
  assign d_try = {rem_r[31:0], dv_r[63]};
  assign d_ge = (d_try >= {1'b0, k_r});
  assign s_try = {rem_r[32:0], dv_r[63:62]};
  assign s_trial = {1'b0, root_r, 2'b01};
  assign s_ge = (s_try >= s_trial);

  always_comb begin
    st_nxt = st_r;
    src_nxt = src_r;
    res_nxt = res_r;
    k_nxt = k_r;
    op_nxt = op_r;
    thd_nxt = thd_r;
    pre_nxt = pre_r;
    errf_nxt = errf_r;
    wa_nxt = wa_r;
    wd_nxt = wd_r;
    wv_nxt = wv_r;
    wi_nxt = wi_r;
    dv_nxt = dv_r;
    rem_nxt = rem_r;
    root_nxt = root_r;
    cnt_nxt = cnt_r;
    flag_nxt = flag_r;
    done_nxt = 1'b0;
    err_nxt = 1'b0;
    mem_we = 1'b0;
    mem_wa = i_reg_addr;
    mem_wd = i_reg_wdata;
    acc_we = 1'b0;
    acc_wt = i_reg_thread;
    acc_wd = i_reg_wdata;
    rdata_nxt = rd(i_reg_thread, i_reg_addr);
    case (st_r)
      calc_queue_pkg::S_IDLE: begin
        // Host writes only land while idle so a command sees stable operands
        if (i_reg_we) begin
          if (i_reg_addr == calc_queue_pkg::ACC_REG) begin
            acc_we = 1'b1;
          end else begin
            mem_we = 1'b1;
          end
        end
        if (i_cmd_valid && i_cmd_num == calc_queue_pkg::CMD_CALC_DATA) begin // RULE15
          src_nxt = i_src_reg[7:0];
          k_nxt = i_constant;
          op_nxt = i_op;
          res_nxt = i_opt_res[7:0]; // RULE16
          pre_nxt = (i_opt_res[15:8] == calc_queue_pkg::PRESAVE_OPT); // RULE16
          thd_nxt = i_thread;
          errf_nxt = (i_src_reg[15:8] != 8'h00);
          wv_nxt = 4'h0;
          wi_nxt = 2'h0;
          st_nxt = calc_queue_pkg::S_PRE;
        end
      end
      calc_queue_pkg::S_PRE: begin
        if (pre_r) begin
          acc_we = 1'b1; // RULE16
          acc_wt = thd_r;
          acc_wd = rd(thd_r, res_r);
        end
        st_nxt = errf_r ? calc_queue_pkg::S_DONE : calc_queue_pkg::S_EXEC;
      end
      calc_queue_pkg::S_EXEC: begin
        st_nxt = calc_queue_pkg::S_WR;
        case (op_r)
          calc_queue_pkg::OP_Q_INIT: begin
            wa_nxt[0] = src_r + calc_queue_pkg::Q_SIZE_OFS; // RULE1
            wd_nxt[0] = k_r;
            wa_nxt[1] = src_r + calc_queue_pkg::Q_HEAD_OFS;
            wd_nxt[1] = 32'h0000_0000;
            wa_nxt[2] = src_r + calc_queue_pkg::Q_CNT_OFS;
            wd_nxt[2] = 32'h0000_0000;
            wv_nxt = 4'h7;
            flag_nxt[thd_r] = calc_queue_pkg::FLAG_ZERO; // RULE18
          end
          calc_queue_pkg::OP_QE_PUSH_HEAD, calc_queue_pkg::OP_QF_PUSH_HEAD,
          calc_queue_pkg::OP_QE_PUSH_TAIL, calc_queue_pkg::OP_QF_PUSH_TAIL: begin
            if (q_full) begin
              if (op_r == calc_queue_pkg::OP_QF_PUSH_HEAD ||
                  op_r == calc_queue_pkg::OP_QF_PUSH_TAIL) begin
                flag_nxt[thd_r] = calc_queue_pkg::FLAG_NEG; // RULE7 RULE9
              end else begin
                errf_nxt = 1'b1; // RULE2 RULE4
              end
            end else begin
              if (op_r == calc_queue_pkg::OP_QE_PUSH_HEAD ||
                  op_r == calc_queue_pkg::OP_QF_PUSH_HEAD) begin
                wa_nxt[0] = ent(src_r, hm1); // RULE2 RULE7
                wa_nxt[3] = src_r + calc_queue_pkg::Q_HEAD_OFS;
                wd_nxt[3] = hm1;
                wv_nxt = 4'hF;
              end else begin
                wa_nxt[0] = ent(src_r, tpos); // RULE4 RULE9
                wv_nxt = 4'h7;
              end
              wd_nxt[0] = k_r;
              wa_nxt[1] = src_r + calc_queue_pkg::Q_CNT_OFS;
              wd_nxt[1] = qcn + 32'h0000_0001;
              wa_nxt[2] = res_r;
              wd_nxt[2] = qcn + 32'h0000_0001;
              if (op_r == calc_queue_pkg::OP_QF_PUSH_HEAD ||
                  op_r == calc_queue_pkg::OP_QF_PUSH_TAIL) begin
                flag_nxt[thd_r] = calc_queue_pkg::FLAG_ZERO; // RULE7 RULE9
              end else begin
                flag_nxt[thd_r] = calc_queue_pkg::FLAG_POS; // RULE18
              end
            end
          end
          calc_queue_pkg::OP_QE_POP_HEAD, calc_queue_pkg::OP_QF_POP_HEAD,
          calc_queue_pkg::OP_QE_POP_TAIL, calc_queue_pkg::OP_QF_POP_TAIL: begin
            if (q_empty) begin
              if (op_r == calc_queue_pkg::OP_QF_POP_HEAD ||
                  op_r == calc_queue_pkg::OP_QF_POP_TAIL) begin
                flag_nxt[thd_r] = calc_queue_pkg::FLAG_NEG; // RULE8 RULE10
              end else begin
                errf_nxt = 1'b1; // RULE3 RULE5
              end
            end else begin
              wa_nxt[0] = res_r;
              wa_nxt[1] = src_r + calc_queue_pkg::Q_CNT_OFS;
              wd_nxt[1] = qcn - 32'h0000_0001;
              if (op_r == calc_queue_pkg::OP_QE_POP_HEAD ||
                  op_r == calc_queue_pkg::OP_QF_POP_HEAD) begin
                wd_nxt[0] = rd(thd_r, ent(src_r, qhd)); // RULE3 RULE8
                wa_nxt[2] = src_r + calc_queue_pkg::Q_HEAD_OFS;
                wd_nxt[2] = hp1;
                wv_nxt = 4'h7;
              end else begin
                wd_nxt[0] = rd(thd_r, ent(src_r, tlast)); // RULE5 RULE10
                wv_nxt = 4'h3;
              end
              if (op_r == calc_queue_pkg::OP_QF_POP_HEAD ||
                  op_r == calc_queue_pkg::OP_QF_POP_TAIL) begin
                flag_nxt[thd_r] = calc_queue_pkg::FLAG_ZERO; // RULE8 RULE10
              end else begin
                flag_nxt[thd_r] = flg({{32{wd_nxt[0][31]}}, wd_nxt[0]}); // RULE18
              end
            end
          end
          calc_queue_pkg::OP_QE_READ, calc_queue_pkg::OP_QF_READ: begin
            if (q_oob) begin
              if (op_r == calc_queue_pkg::OP_QF_READ) begin
                flag_nxt[thd_r] = calc_queue_pkg::FLAG_NEG; // RULE11
              end else begin
                errf_nxt = 1'b1; // RULE6
              end
            end else begin
              wa_nxt[0] = res_r; // RULE6 RULE11
              wd_nxt[0] = rd(thd_r, ent(src_r, epos));
              wv_nxt = 4'h1;
              if (op_r == calc_queue_pkg::OP_QF_READ) begin
                flag_nxt[thd_r] = calc_queue_pkg::FLAG_ZERO; // RULE11
              end else begin
                flag_nxt[thd_r] = flg({{32{wd_nxt[0][31]}}, wd_nxt[0]}); // RULE18
              end
            end
          end
          calc_queue_pkg::OP_MUL_U64: begin
            wa_nxt[0] = res_r; // RULE12
            wd_nxt[0] = prod[31:0];
            wa_nxt[1] = res_r + 8'h01;
            wd_nxt[1] = prod[63:32];
            wv_nxt = 4'h3;
            flag_nxt[thd_r] = flg(prod); // RULE18
          end
          calc_queue_pkg::OP_DIV_64_32: begin
            if (k_r == 32'h0000_0000) begin
              errf_nxt = 1'b1;
            end else begin
              dv_nxt = {a_hi, a_val}; // RULE13
              rem_nxt = 35'h0_0000_0000;
              cnt_nxt = calc_queue_pkg::DIV_STEPS;
              st_nxt = calc_queue_pkg::S_DIV;
            end
          end
          calc_queue_pkg::OP_SQRT_64: begin
            dv_nxt = {a_hi, a_val}; // RULE14
            rem_nxt = 35'h0_0000_0000;
            root_nxt = 32'h0000_0000;
            cnt_nxt = calc_queue_pkg::SQRT_STEPS;
            st_nxt = calc_queue_pkg::S_SQRT;
          end
          default: begin
            errf_nxt = 1'b1;
          end
        endcase
        if (errf_nxt) begin
          st_nxt = calc_queue_pkg::S_DONE;
        end
      end
      calc_queue_pkg::S_DIV: begin
        // Restoring divide, one quotient bit per cycle to keep the adder narrow
        rem_nxt = {2'b00, d_ge ? d_try - {1'b0, k_r} : d_try}; // RULE13
        dv_nxt = {dv_r[62:0], d_ge};
        cnt_nxt = cnt_r - 7'h01;
        if (cnt_r == 7'h01) begin
          wa_nxt[0] = res_r;
          wd_nxt[0] = dv_nxt[31:0];
          wv_nxt = 4'h1;
          flag_nxt[thd_r] = flg({32'h0000_0000, dv_nxt[31:0]}); // RULE18
          st_nxt = calc_queue_pkg::S_WR;
        end
      end
      calc_queue_pkg::S_SQRT: begin
        rem_nxt = s_ge ? s_try - s_trial : s_try; // RULE14
        root_nxt = {root_r[30:0], s_ge};
        dv_nxt = {dv_r[61:0], 2'b00};
        cnt_nxt = cnt_r - 7'h01;
        if (cnt_r == 7'h01) begin
          wa_nxt[0] = res_r;
          wd_nxt[0] = root_nxt;
          wv_nxt = 4'h1;
          flag_nxt[thd_r] = flg({32'h0000_0000, root_nxt}); // RULE18
          st_nxt = calc_queue_pkg::S_WR;
        end
      end
      calc_queue_pkg::S_WR: begin
        if (wv_r[wi_r]) begin
          if (wa_r[wi_r] == calc_queue_pkg::ACC_REG) begin
            acc_we = 1'b1; // RULE17
            acc_wt = thd_r;
            acc_wd = wd_r[wi_r];
          end else begin
            mem_we = 1'b1;
            mem_wa = wa_r[wi_r];
            mem_wd = wd_r[wi_r];
          end
        end
        wi_nxt = wi_r + 2'h1;
        if (wi_r == 2'h3) begin
          st_nxt = calc_queue_pkg::S_DONE;
        end
      end
      calc_queue_pkg::S_DONE: begin
        done_nxt = 1'b1;
        err_nxt = errf_r;
        st_nxt = calc_queue_pkg::S_IDLE;
      end
      default: begin
        st_nxt = calc_queue_pkg::S_IDLE;
      end
    endcase
    busy_nxt = (st_nxt != calc_queue_pkg::S_IDLE);
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_r <= calc_queue_pkg::S_IDLE;
      for (int i = 0; i < NREGS; i++) begin
        mem[i] <= calc_queue_pkg::REG_RST;
      end
      for (int t = 0; t < 2; t++) begin
        acc_r[t] <= calc_queue_pkg::REG_RST;
        flag_r[t] <= calc_queue_pkg::FLAG_RST;
      end
      for (int j = 0; j < 4; j++) begin
        wa_r[j] <= 8'h00;
        wd_r[j] <= calc_queue_pkg::REG_RST;
      end
      src_r <= 8'h00;
      res_r <= 8'h00;
      k_r <= calc_queue_pkg::REG_RST;
      op_r <= 16'h0000;
      thd_r <= 1'b0;
      pre_r <= 1'b0;
      errf_r <= 1'b0;
      wv_r <= 4'h0;
      wi_r <= 2'h0;
      dv_r <= 64'h0000_0000_0000_0000;
      rem_r <= 35'h0_0000_0000;
      root_r <= 32'h0000_0000;
      cnt_r <= 7'h00;
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_cmd_err <= 1'b0;
      o_reg_rdata <= calc_queue_pkg::REG_RST;
      o_zero <= {2{calc_queue_pkg::FLAG_RST[2]}};
      o_pos <= {2{calc_queue_pkg::FLAG_RST[1]}};
      o_neg <= {2{calc_queue_pkg::FLAG_RST[0]}};
    end else begin
      st_r <= st_nxt;
      if (mem_we) begin
        mem[mem_wa] <= mem_wd;
      end
      if (acc_we) begin
        acc_r[acc_wt] <= acc_wd;
      end
      flag_r <= flag_nxt;
      wa_r <= wa_nxt;
      wd_r <= wd_nxt;
      src_r <= src_nxt;
      res_r <= res_nxt;
      k_r <= k_nxt;
      op_r <= op_nxt;
      thd_r <= thd_nxt;
      pre_r <= pre_nxt;
      errf_r <= errf_nxt;
      wv_r <= wv_nxt;
      wi_r <= wi_nxt;
      dv_r <= dv_nxt;
      rem_r <= rem_nxt;
      root_r <= root_nxt;
      cnt_r <= cnt_nxt;
      o_busy <= busy_nxt;
      o_done <= done_nxt;
      o_cmd_err <= err_nxt;
      o_reg_rdata <= rdata_nxt;
      o_zero <= {flag_nxt[1][2], flag_nxt[0][2]};
      o_pos <= {flag_nxt[1][1], flag_nxt[0][1]};
      o_neg <= {flag_nxt[1][0], flag_nxt[0][0]};
    end
  end

endmodule

//--- rtl/calc_queue_pkg.sv
package calc_queue_pkg;
  localparam logic [15:0] CMD_CALC_DATA = 16'h00C8;
  localparam logic [7:0] PRESAVE_OPT = 8'h01;
  localparam int NUM_REGS = 256;
  localparam logic [7:0] ACC_REG = 8'h0A;
  localparam logic [7:0] Q_SIZE_OFS = 8'h00;
  localparam logic [7:0] Q_HEAD_OFS = 8'h01;
  localparam logic [7:0] Q_CNT_OFS = 8'h02;
  localparam logic [7:0] Q_DATA_OFS = 8'h03;
  localparam logic [15:0] OP_Q_INIT = 16'h0019;
  localparam logic [15:0] OP_QE_PUSH_HEAD = 16'h001A;
  localparam logic [15:0] OP_QE_POP_HEAD = 16'h001B;
  localparam logic [15:0] OP_QE_PUSH_TAIL = 16'h001C;
  localparam logic [15:0] OP_QE_POP_TAIL = 16'h001D;
  localparam logic [15:0] OP_QE_READ = 16'h001E;
  localparam logic [15:0] OP_QF_PUSH_HEAD = 16'h001F;
  localparam logic [15:0] OP_QF_POP_HEAD = 16'h0020;
  localparam logic [15:0] OP_QF_PUSH_TAIL = 16'h0021;
  localparam logic [15:0] OP_QF_POP_TAIL = 16'h0022;
  localparam logic [15:0] OP_QF_READ = 16'h0023;
  localparam logic [15:0] OP_MUL_U64 = 16'h0064;
  localparam logic [15:0] OP_DIV_64_32 = 16'h0065;
  localparam logic [15:0] OP_SQRT_64 = 16'h0066;
  localparam logic [6:0] DIV_STEPS = 7'h40;
  localparam logic [6:0] SQRT_STEPS = 7'h20;
  localparam logic [31:0] REG_RST = 32'h0000_0000;
  // Flag order is {zero, positive, negative}
  localparam logic [2:0] FLAG_ZERO = 3'h4;
  localparam logic [2:0] FLAG_POS = 3'h2;
  localparam logic [2:0] FLAG_NEG = 3'h1;
  localparam logic [2:0] FLAG_RST = 3'h4;
  typedef enum logic [6:0] {
    S_IDLE = 7'b0000001,
    S_PRE  = 7'b0000010,
    S_EXEC = 7'b0000100,
    S_DIV  = 7'b0001000,
    S_SQRT = 7'b0010000,
    S_WR   = 7'b0100000,
    S_DONE = 7'b1000000
  } state_t;
endpackage

//--- test/calc_queue_assertions.sv
`timescale 1ns/1ps
module calc_queue_checker #(
  parameter int NREGS = 256
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Command frame
  input wire logic i_cmd_valid,
  input wire logic [15:0] i_cmd_num,
  input wire logic [15:0] i_src_reg,
  input wire logic [15:0] i_op,
  input wire logic i_thread,
  // Status
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic o_cmd_err,
  input wire logic [1:0] o_zero,
  input wire logic [1:0] o_pos,
  input wire logic [1:0] o_neg
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  logic take;
  logic src_ok;
  logic known_op;
  assign take = i_cmd_valid && !o_busy && (i_cmd_num == calc_queue_pkg::CMD_CALC_DATA);
  assign src_ok = (i_src_reg[15:8] == 8'h00);
  assign known_op = (i_op >= 16'h0019 && i_op <= 16'h0023) ||
    (i_op >= 16'h0064 && i_op <= 16'h0066);
  sequence s_bad_take;
    take && src_ok && !known_op;
  endsequence
  sequence s_err_done;
    o_done && o_cmd_err;
  endsequence
  sequence s_ok_done;
    o_done && !o_cmd_err;
  endsequence
  a_busy_after_take: assert property (take |=> o_busy)
    else $error("busy not raised after command taken");
  a_done_bounded: assert property (take |-> ##[2:90] o_done)
    else $error("command never completed");
  a_err_with_done: assert property (o_cmd_err |-> o_done)
    else $error("error pulse without done");
  a_done_single: assert property (o_done |=> !o_done)
    else $error("done longer than one cycle");
  a_busy_drop: assert property ($fell(o_busy) |-> o_done)
    else $error("busy fell without done");
  a_bad_op: assert property (s_bad_take |-> ##4 s_err_done)
    else $error("unknown operation not refused");
  a_mul_latency: assert property (take && src_ok && i_op == calc_queue_pkg::OP_MUL_U64
    |-> ##8 s_ok_done)
    else $error("multiply completion wrong");
  a_flag_noerr: assert property (take && src_ok && i_op >= 16'h001F && i_op <= 16'h0023
    |-> ##8 s_ok_done)
    else $error("flag queue operation raised error");
  a_other_cmd: assert property (i_cmd_valid && !o_busy
    && i_cmd_num != calc_queue_pkg::CMD_CALC_DATA |=> !o_busy)
    else $error("foreign command number acted on");
  a_flags_onehot: assert property ($onehot({o_zero[0], o_pos[0], o_neg[0]})
    && $onehot({o_zero[1], o_pos[1], o_neg[1]}))
    else $error("flag set not one-hot");
  // A thread two command may follow a short error, so only the first five cycles
  a_thread_iso: assert property (take && !i_thread
    |=> $stable({o_zero[1], o_pos[1], o_neg[1]})[*5])
    else $error("thread one command moved thread two flags");
endmodule
bind register_calc_queue_unit calc_queue_checker #(.NREGS(NREGS)) checker_inst (
  .i_clk(i_clk),
  .i_arst_n(i_arst_n),
  .i_cmd_valid(i_cmd_valid),
  .i_cmd_num(i_cmd_num),
  .i_src_reg(i_src_reg),
  .i_op(i_op),
  .i_thread(i_thread),
  .o_busy(o_busy),
  .o_done(o_done),
  .o_cmd_err(o_cmd_err),
  .o_zero(o_zero),
  .o_pos(o_pos),
  .o_neg(o_neg)
);

//--- test/cmd_host.sv
`timescale 1ns/1ps
module cmd_host (
  // Clock and answer
  input wire logic i_clk,
  input wire logic i_done,
  input wire logic i_cmd_err,
  // Command frame
  output logic o_cmd_valid,
  output logic [15:0] o_cmd_num,
  output logic [15:0] o_src_reg,
  output logic [31:0] o_constant,
  output logic [15:0] o_op,
  output logic [15:0] o_opt_res,
  output logic o_thread
);
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd_num = 16'h0000;
    o_src_reg = 16'h0000;
    o_constant = 32'h0000_0000;
    o_op = 16'h0000;
    o_opt_res = 16'h0000;
    o_thread = 1'b0;
  end
  // Fields scrambled after the take so a stale frame is never mistaken for a live one
  task automatic send(input logic [15:0] num, input logic [15:0] src, input logic [31:0] k,
      input logic [15:0] op, input logic [15:0] opt, input logic thr, input int lim,
      output logic seen, output logic err);
    int n;
    seen = 1'b0;
    err = 1'b0;
    n = 0;
    @(negedge i_clk);
    o_cmd_valid = 1'b1;
    o_cmd_num = num;
    o_src_reg = src;
    o_constant = k;
    o_op = op;
    o_opt_res = opt;
    o_thread = thr;
    @(negedge i_clk);
    o_cmd_valid = 1'b0;
    o_cmd_num = ~num;
    o_src_reg = ~src;
    o_constant = ~k;
    o_op = ~op;
    o_opt_res = ~opt;
    o_thread = ~thr;
    while (!seen && n < lim) begin
      if (i_done === 1'b1) begin
        seen = 1'b1;
        err = i_cmd_err;
      end else begin
        n++;
        @(negedge i_clk);
      end
    end
  endtask
endmodule

//--- test/tb_register_calc_queue_unit.sv
`timescale 1ns/1ps
module tb_register_calc_queue_unit;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic we = 1'b0;
  logic rthr = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata;
  logic busy, done, err, cv, thr, cs, ce;
  logic [1:0] z, p, n;
  logic [15:0] cnum, src, op, opt;
  logic [31:0] k, rs, a, b, d;
  logic [63:0] v;
  int mismatches = 0;
  int comparisons = 0;
  always #50 clk = ~clk;
  cmd_host cmd_host_inst (.i_clk(clk), .i_done(done), .i_cmd_err(err), .o_cmd_valid(cv),
    .o_cmd_num(cnum), .o_src_reg(src), .o_constant(k), .o_op(op), .o_opt_res(opt),
    .o_thread(thr));
  register_calc_queue_unit register_calc_queue_unit_inst (.i_clk(clk), .i_arst_n(rst_n),
    .i_cmd_valid(cv), .i_cmd_num(cnum), .i_src_reg(src), .i_constant(k), .i_op(op),
    .i_opt_res(opt), .i_thread(thr), .i_reg_we(we), .i_reg_addr(addr), .i_reg_thread(rthr),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_busy(busy), .o_done(done),
    .o_cmd_err(err), .o_zero(z), .o_pos(p), .o_neg(n));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] isqrt(input logic [63:0] x);
    logic [31:0] r;
    logic [31:0] t;
    r = 32'h0000_0000;
    for (int i = 31; i >= 0; i--) begin
      t = r | (32'h0000_0001 << i);
      if ({32'h0000_0000, t} * {32'h0000_0000, t} <= x) r = t;
    end
    return r;
  endfunction
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
    @(negedge clk);
    we = 1'b1;
    addr = ad;
    wdata = dt;
    @(negedge clk);
    we = 1'b0;
    wdata = ~dt;
  endtask
  task automatic rchk(input logic [7:0] ad, input logic [31:0] e);
    @(negedge clk);
    addr = ad;
    @(negedge clk);
    chk("register", {32'h0000_0000, e}, {32'h0000_0000, rdata});
  endtask
  task automatic fchk(input logic t, input logic [2:0] e);
    chk("flags", {61'h0, e}, {61'h0, z[t], p[t], n[t]});
  endtask
  task automatic cmd(input logic [15:0] s, input logic [31:0] c, input logic [15:0] o,
      input logic [15:0] r, input logic t);
    cmd_host_inst.send(calc_queue_pkg::CMD_CALC_DATA, s, c, o, r, t, 120, cs, ce);
    chk("done", 64'h1, {63'h0, cs});
    chk("busy", 64'h0, {63'h0, busy});
  endtask
  // Queue at base 40, result in register 60, thread one
  task automatic q(input logic [15:0] o, input logic [31:0] c, input logic e);
    cmd(16'h0028, c, o, 16'h003C, 1'b0);
    chk("cmd_err", {63'h0, e}, {63'h0, ce});
  endtask
  initial begin
    #(100 * 30000);
    mismatches++;
    conclude();
  end
  initial begin
    rs = 32'h0000_e2e7;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    q(calc_queue_pkg::OP_Q_INIT, 32'h0000_0003, 1'b0);
    rchk(8'h28, 32'h0000_0003);
    rchk(8'h2A, 32'h0000_0000);
    q(calc_queue_pkg::OP_QE_POP_HEAD, 32'h0000_0000, 1'b1);
    q(calc_queue_pkg::OP_QE_PUSH_TAIL, 32'h0000_0011, 1'b0);
    rchk(8'h3C, 32'h0000_0001);
    q(calc_queue_pkg::OP_QE_PUSH_HEAD, 32'h0000_0022, 1'b0);
    rchk(8'h3C, 32'h0000_0002);
    rchk(8'h29, 32'h0000_0002);
    q(calc_queue_pkg::OP_QE_PUSH_TAIL, 32'h0000_0033, 1'b0);
    q(calc_queue_pkg::OP_QE_PUSH_HEAD, 32'h0000_0044, 1'b1);
    q(calc_queue_pkg::OP_QE_PUSH_TAIL, 32'h0000_0044, 1'b1);
    q(calc_queue_pkg::OP_QF_PUSH_HEAD, 32'h0000_0044, 1'b0);
    fchk(1'b0, calc_queue_pkg::FLAG_NEG);
    q(calc_queue_pkg::OP_QF_PUSH_TAIL, 32'h0000_0044, 1'b0);
    fchk(1'b0, calc_queue_pkg::FLAG_NEG);
    q(calc_queue_pkg::OP_QE_READ, 32'h0000_0000, 1'b0);
    rchk(8'h3C, 32'h0000_0022);
    q(calc_queue_pkg::OP_QE_READ, 32'h0000_0003, 1'b1);
    q(calc_queue_pkg::OP_QF_READ, 32'h0000_0005, 1'b0);
    fchk(1'b0, calc_queue_pkg::FLAG_NEG);
    q(calc_queue_pkg::OP_QF_READ, 32'h0000_0002, 1'b0);
    rchk(8'h3C, 32'h0000_0033);
    fchk(1'b0, calc_queue_pkg::FLAG_ZERO);
    q(calc_queue_pkg::OP_QE_POP_HEAD, 32'h0000_0000, 1'b0);
    rchk(8'h3C, 32'h0000_0022);
    q(calc_queue_pkg::OP_QE_POP_TAIL, 32'h0000_0000, 1'b0);
    rchk(8'h3C, 32'h0000_0033);
    q(calc_queue_pkg::OP_QF_POP_TAIL, 32'h0000_0000, 1'b0);
    rchk(8'h3C, 32'h0000_0011);
    fchk(1'b0, calc_queue_pkg::FLAG_ZERO);
    q(calc_queue_pkg::OP_QF_POP_HEAD, 32'h0000_0000, 1'b0);
    fchk(1'b0, calc_queue_pkg::FLAG_NEG);
    q(calc_queue_pkg::OP_QE_POP_TAIL, 32'h0000_0000, 1'b1);
    for (int i = 0; i < 6; i++) begin
      rs = lfsr(lfsr(rs));
      a = (i == 0) ? 32'hFFFF_FFFF : rs;
      rs = lfsr(lfsr(rs));
      b = (i == 0) ? 32'hFFFF_FFFF : rs;
      d = (i == 0) ? 32'h0000_0001 : {rs[31:17], 16'h0000, 1'b1};
      wr(8'h32, a);
      cmd(16'h0032, b, calc_queue_pkg::OP_MUL_U64, 16'h0046, 1'b0);
      v = {32'h0000_0000, a} * {32'h0000_0000, b};
      rchk(8'h46, v[31:0]);
      rchk(8'h47, v[63:32]);
      v = {b, a};
      wr(8'h50, a);
      wr(8'h51, b);
      cmd(16'h0050, d, calc_queue_pkg::OP_DIV_64_32, 16'h0048, 1'b0);
      rchk(8'h48, 32'(v / {32'h0000_0000, d}));
      cmd(16'h0050, 32'h0000_0000, calc_queue_pkg::OP_SQRT_64, 16'h0049, 1'b0);
      rchk(8'h49, isqrt(v));
    end
    cmd(16'h0050, 32'h0000_0000, calc_queue_pkg::OP_DIV_64_32, 16'h0048, 1'b0);
    chk("div_zero_err", 64'h1, {63'h0, ce});
    cmd(16'h0032, 32'h0000_0000, 16'h0005, 16'h0048, 1'b0);
    chk("bad_op_err", 64'h1, {63'h0, ce});
    cmd_host_inst.send(16'h00C9, 16'h0032, 32'h0000_0001, calc_queue_pkg::OP_MUL_U64,
      16'h0048, 1'b0, 12, cs, ce);
    chk("foreign_ignored", 64'h0, {63'h0, cs});
    rthr = 1'b0;
    wr(8'h0A, 32'h0BAD_0001);
    wr(8'h4A, 32'h1234_5678);
    wr(8'h32, 32'h0000_0003);
    cmd(16'h0032, 32'h0000_0005, calc_queue_pkg::OP_MUL_U64, 16'h014A, 1'b1);
    rchk(8'h4A, 32'h0000_000F);
    fchk(1'b1, calc_queue_pkg::FLAG_POS);
    rchk(8'h0A, 32'h0BAD_0001);
    rthr = 1'b1;
    rchk(8'h0A, 32'h1234_5678);
    conclude();
  end
endmodule
